// ---- src/sfp_flash_pins.sv ----
`timescale 1ns/100ps
// Function
// R1: While deselected, every data lane output is floated.
// R2: Select low lets instruction, address and data bits in and data out.
// R3: No instruction accepted until a select falling edge after power-up.
// R4: Running erase, program or status cycle completes after deselect.
// R5: Single lane: host bits sampled from serial_in on rising clock.
// R6: Single lane: read data shifted out on lane one on falling clock.
// R7: Dual/quad lanes are bidirectional; in on rise, out on fall. Code uses dual/quad lanes for output only; input is taken on lane zero alone.
// R8: Quad instructions honoured only with four_lane_enable set.
// R9: With four_lane_enable, protect and pause pins are lanes two, three.
// R10: Asserted write_protect_n with status_lock_bit blocks status writes.
// R11: Range, side, unit and invert bits protect 4KB up to whole array.
// R12: With four_lane_enable, write-protect pin function is ignored.
// R13: Pause while selected floats output, ignores data and clock.
// R14: Release of pause resumes from the held state.
// R15: With four_lane_enable, the pause function is disabled.
// R16: Array of 1,048,576 bytes; program writes at most one 256-byte page.
// R17: Erase 4KB, 32KB, 64KB units; program and erase suspend/resume.
// R18: 64-bit unique identifier readable by the host.
// R19: Three 256-byte security registers with one-time lock bits.
// R20: Clock mode 0 or 3; idle clock level at select edges differs.
// R21: Pause starts or ends on pin edge if clock low, else next fall.
// R22: Host keeps select low in a pause; deselect resets instruction state.
// R23: Opcode then address are shifted most significant bit first.
// R24: Deselect before completion abandons the instruction.
module sfp_flash_pins (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire sfp_pkg::sfp_lanes_s i_lane_in,
  output sfp_pkg::sfp_lanes_s o_lane_out,
  output sfp_pkg::sfp_lanes_s o_lane_oe,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  import sfp_pkg::*;

  // ==========
  // Pin synchronisers
  logic [5:0] sy1;
  logic [5:0] sy2;
  logic sclk_d;
  logic cs_d;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      // Pause and protect lanes idle high, else a false pause follows reset
      sy1 <= 6'h0c;
      sy2 <= 6'h0c;
      sclk_d <= 1'b0;
      cs_d <= 1'b0;
    end else begin
      sy1 <= {i_cs_n, i_sclk, i_lane_in};
      sy2 <= sy1;
      sclk_d <= sy2[4];
      cs_d <= sy2[5];
    end
  end

  logic cs_n;
  logic sclk;
  logic din0;
  logic wp_n;
  logic hold_n;
  assign cs_n = sy2[5];
  assign sclk = sy2[4];
  assign din0 = sy2[0];
  assign wp_n = sy2[2];
  assign hold_n = sy2[3];

  // ==========
  // State
  logic armed;
  logic hold_act;
  logic wel;
  logic status_lock_bit;
  logic small_unit_pick;
  logic top_or_bottom;
  logic [2:0] protect_range_bits;
  logic srp1;
  logic four_lane_enable;
  logic [2:0] lock_bits;
  logic protect_invert;
  logic sus;
  logic eng_run;
  logic eng_prog;
  logic eng_sreg;
  logic [19:0] eng_addr;
  logic [20:0] eng_left;
  sfp_ser_e st;
  logic [7:0] op;
  logic [5:0] cnt;
  logic [23:0] sh;
  logic [19:0] addr;
  logic [2:0] obit;
  logic [2:0] w;
  logic [1:0] nb;
  logic [15:0] wsr;
  logic cmd_ok;
  logic addr_ok;
  logic pp_any;
  logic [3:0] oe_want;
  logic [31:0] uid_lo;
  logic [31:0] uid_hi;
  logic [7:0] mem [0:MEM_SIZE-1];
  logic [7:0] sreg [0:SREG_COUNT*SREG_SIZE-1];
  logic [7:0] pbuf [0:PAGE_SIZE-1];
  logic [255:0] pvalid;

  function automatic logic prot(input logic [19:0] a, input logic [2:0] bp, input logic tb,
                                input logic sec, input logic cmp);
    logic [20:0] off;
    logic [20:0] sz;
    off = {1'b0, tb ? a : ~a};
    if (bp == 3'd0) begin
      sz = 21'h000000;
    end else if (sec) begin
      sz = (bp > 3'd3) ? BLK32_SIZE : (SECT_SIZE << (bp - 3'd1));
    end else begin
      sz = (bp > 3'd4) ? MEM_SIZE : (BLK64_SIZE << (bp - 3'd1));
    end
    return (off < sz) ^ cmp;
  endfunction

  // ==========
  // Edge events
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  logic ev_rise;
  logic ev_fall;
  logic busy;
  assign rise = sclk & ~sclk_d;
  assign fall = ~sclk & sclk_d;
  assign cs_fall = ~cs_n & cs_d;
  assign cs_rise = cs_n & ~cs_d;
  // Edges alone, so idle level at select does not matter [R20]
  assign ev_rise = rise & ~cs_n & armed & ~hold_act; // [R2] [R5] [R13]
  assign ev_fall = fall & ~cs_n & armed & ~hold_act;
  assign busy = eng_run & ~sus;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      armed <= 1'b0;
    end else if (cs_fall) begin
      armed <= 1'b1; // [R3]
    end
  end

  // Deselect or quad mode drops the pause at once
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || cs_n || four_lane_enable) begin
      hold_act <= 1'b0; // [R15] [R22]
    end else if (!sclk) begin
      hold_act <= ~hold_n; // [R21] [R13] [R14]
    end
  end

  // ==========
  // Serial decoder
  logic [7:0] next_byte;
  logic [3:0] osum;
  logic [1:0] ssel;
  logic sel_ok;
  logic [9:0] sidx;
  assign next_byte = {sh[6:0], din0}; // [R23]
  assign osum = {1'b0, obit} + {1'b0, w};
  assign ssel = addr[13:12];
  assign sel_ok = ssel != 2'd0;
  assign sidx = {ssel - 2'd1, addr[7:0]};

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= ST_CMD;
      op <= 8'h00;
      cnt <= 6'd0;
      sh <= 24'h000000;
      addr <= 20'h00000;
      obit <= 3'd0;
      w <= 3'd1;
      nb <= 2'd0;
      wsr <= 16'h0000;
      cmd_ok <= 1'b0;
      addr_ok <= 1'b0;
      pp_any <= 1'b0;
    end else if (cs_n) begin
      st <= ST_CMD; // [R24] [R22]
      cnt <= 6'd0;
      obit <= 3'd0;
      nb <= 2'd0;
      cmd_ok <= 1'b0;
      addr_ok <= 1'b0;
      pp_any <= 1'b0;
    end else if (ev_rise) begin
      sh <= {sh[22:0], din0}; // [R5] [R7]
      case (st)
        ST_CMD: begin
          cnt <= cnt + 6'd1;
          if (cnt == OP_BITS - 6'd1) begin
            op <= next_byte;
            cmd_ok <= 1'b1;
            cnt <= 6'd0;
            w <= 3'd1;
            if (busy && next_byte != OP_RDSR1 && next_byte != OP_RDSR2 && next_byte != OP_SUSP) begin
              st <= ST_SKIP;
            end else begin
              case (next_byte)
                OP_RDSR1, OP_RDSR2: st <= ST_OUT;
                OP_WRSR: st <= ST_IN;
                OP_UID: begin
                  st <= ST_DUMMY; // [R18]
                  addr <= 20'h00000;
                end
                OP_QOUT: st <= four_lane_enable ? ST_ADDR : ST_SKIP; // [R8]
                OP_READ, OP_FAST, OP_DOUT, OP_RDSEC, OP_PP, OP_PSEC, OP_ESEC, OP_SE, OP_BE32,
                OP_BE64: st <= ST_ADDR;
                default: st <= ST_SKIP;
              endcase
            end
          end
        end
        ST_ADDR: begin
          cnt <= cnt + 6'd1;
          if (cnt == ADDR_BITS - 6'd1) begin
            addr <= {sh[18:0], din0}; // [R23]
            addr_ok <= 1'b1;
            cnt <= 6'd0;
            case (op)
              OP_READ: st <= ST_OUT;
              OP_FAST, OP_RDSEC: st <= ST_DUMMY;
              OP_DOUT: begin
                st <= ST_DUMMY;
                w <= 3'd2;
              end
              OP_QOUT: begin
                st <= ST_DUMMY;
                w <= 3'd4;
              end
              OP_PP, OP_PSEC: st <= ST_IN;
              default: st <= ST_SKIP;
            endcase
          end
        end
        ST_DUMMY: begin
          cnt <= cnt + 6'd1;
          if (cnt == ((op == OP_UID) ? DUMMY_UID : DUMMY_FAST) - 6'd1) begin
            cnt <= 6'd0;
            st <= ST_OUT;
          end
        end
        ST_IN: begin
          cnt <= cnt + 6'd1;
          if (cnt[2:0] == 3'd7) begin
            cnt <= 6'd0;
            if (op == OP_WRSR) begin
              if (nb == 2'd0) begin
                wsr[15:8] <= next_byte;
              end else if (nb == 2'd1) begin
                wsr[7:0] <= next_byte;
              end
              if (nb != 2'd2) begin
                nb <= nb + 2'd1;
              end
            end else begin
              addr[7:0] <= addr[7:0] + 8'd1; // Wraps inside the page [R16]
              pp_any <= 1'b1;
            end
          end
        end
        default: st <= st;
      endcase
    end else if (ev_fall && st == ST_OUT) begin
      obit <= osum[2:0]; // [R6] [R7]
      if (osum[3]) begin
        addr <= addr + 20'd1;
      end
    end
  end

  // ==========
  // Read data path
  logic [7:0] sr1_val;
  logic [7:0] sr2_val;
  logic [63:0] uid_sh;
  logic [7:0] rbyte;
  logic [7:0] bsh;
  always_comb begin
    sr1_val = 8'h00;
    sr1_val[S1_BUSY] = busy;
    sr1_val[S1_WEL] = wel;
    sr1_val[S1_BP +: 3] = protect_range_bits;
    sr1_val[S1_TB] = top_or_bottom;
    sr1_val[S1_SEC] = small_unit_pick;
    sr1_val[S1_STATUS_LOCK_BIT] = status_lock_bit;
    sr2_val = 8'h00;
    sr2_val[S2_SRP1] = srp1;
    sr2_val[S2_QE] = four_lane_enable;
    sr2_val[S2_LB +: 3] = lock_bits;
    sr2_val[S2_CMP] = protect_invert;
    sr2_val[S2_SUS] = sus;
    uid_sh = {uid_hi, uid_lo} << {addr[2:0], 3'b000};
    case (op)
      OP_RDSR1: rbyte = sr1_val;
      OP_RDSR2: rbyte = sr2_val;
      OP_UID: rbyte = uid_sh[63:56]; // [R18]
      OP_RDSEC: rbyte = sel_ok ? sreg[sidx] : 8'hff; // [R19]
      default: rbyte = mem[addr];
    endcase
    bsh = rbyte << obit;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || cs_n) begin
      o_lane_out <= sfp_lanes_s'(4'h0);
      oe_want <= 4'h0; // [R1]
    end else if (ev_fall && st == ST_OUT) begin
      case (w)
        3'd4: begin
          o_lane_out <= sfp_lanes_s'(bsh[7:4]); // [R9] [R7]
          oe_want <= 4'hf;
        end
        3'd2: begin
          o_lane_out <= sfp_lanes_s'({2'b00, bsh[7:6]}); // [R7]
          oe_want <= 4'h3;
        end
        default: begin
          o_lane_out <= sfp_lanes_s'({2'b00, bsh[7], 1'b0}); // [R6]
          oe_want <= 4'h2;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || cs_n || hold_act) begin
      o_lane_oe <= sfp_lanes_s'(4'h0); // [R1] [R13]
    end else begin
      o_lane_oe <= sfp_lanes_s'(oe_want);
    end
  end

  // ==========
  // Command execution at deselect
  logic exec;
  logic ok_wr;
  logic wr_locked;
  logic is_erase;
  logic is_ce;
  logic [20:0] er_sz;
  logic [19:0] er_base;
  logic go_pp;
  logic go_ps;
  logic go_er;
  logic go_es;
  logic go_ce;
  assign exec = cs_rise & cmd_ok; // [R24]
  assign ok_wr = wel & ~eng_run;
  // Pin ignored when it carries lane two
  assign wr_locked = status_lock_bit & ~wp_n & ~four_lane_enable; // [R10] [R12]
  assign is_erase = op == OP_SE || op == OP_BE32 || op == OP_BE64;
  assign is_ce = op == OP_CE || op == OP_CE2;
  assign er_sz = (op == OP_SE) ? SECT_SIZE : (op == OP_BE32) ? BLK32_SIZE : BLK64_SIZE; // [R17]
  assign er_base = addr & ~(er_sz[19:0] - 20'd1);
  assign go_pp = exec & ok_wr & addr_ok & pp_any & (op == OP_PP) & // [R11]
                 ~prot(addr, protect_range_bits, top_or_bottom, small_unit_pick, protect_invert);
  assign go_er = exec & ok_wr & addr_ok & is_erase &
                 ~prot(er_base, protect_range_bits, top_or_bottom, small_unit_pick, protect_invert) &
                 ~prot(er_base + er_sz[19:0] - 20'd1, protect_range_bits, top_or_bottom, small_unit_pick,
                       protect_invert); // [R11]
  assign go_ce = exec & ok_wr & is_ce & (protect_range_bits == 3'd0) & ~protect_invert;
  assign go_ps = exec & ok_wr & addr_ok & pp_any & (op == OP_PSEC) & sel_ok & ~lock_bits[ssel - 2'd1];
  assign go_es = exec & ok_wr & addr_ok & (op == OP_ESEC) & sel_ok & ~lock_bits[ssel - 2'd1]; // [R19]

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      {status_lock_bit, small_unit_pick, top_or_bottom, protect_range_bits, wel} <= SR1_RESET[7:1];
      sus <= SR2_RESET[S2_SUS];
      protect_invert <= SR2_RESET[S2_CMP];
      lock_bits <= SR2_RESET[S2_LB +: 3];
      four_lane_enable <= SR2_RESET[S2_QE];
      srp1 <= SR2_RESET[S2_SRP1];
    end else if (exec) begin
      case (op)
        OP_WREN: wel <= busy ? wel : 1'b1;
        OP_WRDI: wel <= busy ? wel : 1'b0;
        OP_WRSR: begin
          if (ok_wr && nb != 2'd0) begin
            wel <= 1'b0;
            if (!wr_locked) begin
              status_lock_bit <= wsr[8 + S1_STATUS_LOCK_BIT]; // [R10]
              small_unit_pick <= wsr[8 + S1_SEC];
              top_or_bottom <= wsr[8 + S1_TB];
              protect_range_bits <= wsr[8 + S1_BP +: 3];
              if (nb == 2'd2) begin
                srp1 <= wsr[S2_SRP1];
                four_lane_enable <= wsr[S2_QE];
                lock_bits <= lock_bits | wsr[S2_LB +: 3]; // One-time: writes never clear, only reset does [R19]
                protect_invert <= wsr[S2_CMP];
              end
            end
          end
        end
        OP_SUSP: sus <= eng_run ? 1'b1 : sus; // [R17]
        OP_RESUME: sus <= 1'b0;
        default: wel <= (go_pp | go_ps | go_er | go_es | go_ce) ? 1'b0 : wel;
      endcase
    end
  end

  // ==========
  // Program and erase engine, runs regardless of select
  logic [9:0] eidx;
  assign eidx = {eng_addr[13:12] - 2'd1, eng_addr[7:0]};
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      eng_run <= 1'b0;
      eng_prog <= 1'b0;
      eng_sreg <= 1'b0;
      eng_addr <= 20'h00000;
      eng_left <= 21'h000000;
    end else if (go_pp || go_ps) begin
      eng_run <= 1'b1;
      eng_prog <= 1'b1;
      eng_sreg <= go_ps;
      eng_addr <= {addr[19:8], 8'h00}; // One page at most [R16]
      eng_left <= PAGE_SIZE;
    end else if (go_er || go_ce || go_es) begin
      eng_run <= 1'b1;
      eng_prog <= 1'b0;
      eng_sreg <= go_es;
      eng_addr <= go_ce ? 20'h00000 : go_es ? {addr[19:8], 8'h00} : er_base;
      eng_left <= go_ce ? MEM_SIZE : go_es ? SREG_SIZE : er_sz;
    end else if (busy) begin
      if (eng_sreg) begin
        if (!eng_prog) begin
          sreg[eidx] <= 8'hff;
        end else if (pvalid[eng_addr[7:0]]) begin
          sreg[eidx] <= sreg[eidx] & pbuf[eng_addr[7:0]];
        end
      end else begin
        if (!eng_prog) begin
          mem[eng_addr] <= 8'hff;
        end else if (pvalid[eng_addr[7:0]]) begin
          mem[eng_addr] <= mem[eng_addr] & pbuf[eng_addr[7:0]];
        end
      end
      eng_addr <= eng_addr + 20'd1;
      eng_left <= eng_left - 21'd1;
      if (eng_left == 21'd1) begin
        eng_run <= 1'b0; // [R4]
      end
    end
  end

  // Page buffer is frozen while an engine job, even suspended, owns it
  logic pb_we;
  assign pb_we = ev_rise & (st == ST_IN) & (cnt[2:0] == 3'd7) & (op != OP_WRSR) & ~eng_run;
  always_ff @(posedge i_clk) begin
    if (pb_we) begin
      pbuf[addr[7:0]] <= next_byte;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || (cs_fall && !eng_run)) begin
      pvalid <= 256'h0;
    end else if (pb_we) begin
      pvalid[addr[7:0]] <= 1'b1;
    end
  end

  // ==========
  // APB slave, one access cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      uid_lo <= UID_RESET[31:0];
      uid_hi <= UID_RESET[63:32];
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
      if (i_psel && !i_penable) begin
        case (i_paddr)
          REG_STAT: o_prdata <= {14'h0000, hold_act, armed, sr2_val, sr1_val};
          REG_UID_LO: o_prdata <= uid_lo;
          REG_UID_HI: o_prdata <= uid_hi;
          default: o_pslverr <= 1'b1;
        endcase
      end
      if (i_psel && i_penable && o_pready && i_pwrite) begin
        if (i_paddr == REG_UID_LO) begin
          uid_lo <= i_pwdata;
        end
        if (i_paddr == REG_UID_HI) begin
          uid_hi <= i_pwdata;
        end
      end
    end
  end
endmodule

// ---- src/sfp_pkg.sv ----
package sfp_pkg;
  // ==========
  // Array geometry
  localparam logic [20:0] MEM_SIZE = 21'h100000;
  localparam logic [20:0] PAGE_SIZE = 21'h000100;
  localparam logic [20:0] SECT_SIZE = 21'h001000;
  localparam logic [20:0] BLK32_SIZE = 21'h008000;
  localparam logic [20:0] BLK64_SIZE = 21'h010000;
  localparam logic [20:0] SREG_SIZE = 21'h000100;
  localparam int SREG_COUNT = 3;
  localparam logic [5:0] OP_BITS = 6'd8;
  localparam logic [5:0] ADDR_BITS = 6'd24;
  localparam logic [5:0] DUMMY_FAST = 6'd8;
  localparam logic [5:0] DUMMY_UID = 6'd32;
  // ==========
  // Status fields
  localparam logic [7:0] SR1_RESET = 8'h00;
  localparam logic [7:0] SR2_RESET = 8'h00;
  localparam int S1_BUSY = 0;
  localparam int S1_WEL = 1;
  localparam int S1_BP = 2;
  localparam int S1_TB = 5;
  localparam int S1_SEC = 6;
  localparam int S1_STATUS_LOCK_BIT = 7;
  localparam int S2_SRP1 = 0;
  localparam int S2_QE = 1;
  localparam int S2_LB = 3;
  localparam int S2_CMP = 6;
  localparam int S2_SUS = 7;
  // ==========
  // Opcodes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_DOUT = 8'h3b;
  localparam logic [7:0] OP_QOUT = 8'h6b;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hd8;
  localparam logic [7:0] OP_CE = 8'hc7;
  localparam logic [7:0] OP_CE2 = 8'h60;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_UID = 8'h4b;
  localparam logic [7:0] OP_ESEC = 8'h44;
  localparam logic [7:0] OP_PSEC = 8'h42;
  localparam logic [7:0] OP_RDSEC = 8'h48;
  // ==========
  // Register map
  localparam logic [11:0] REG_STAT = 12'h000;
  localparam logic [11:0] REG_UID_LO = 12'h004;
  localparam logic [11:0] REG_UID_HI = 12'h008;
  // Arbitrary value
  localparam logic [63:0] UID_RESET = 64'h0123456789abcdef;
  typedef enum logic [5:0] {
    ST_CMD = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_DUMMY = 6'b000100,
    ST_IN = 6'b001000,
    ST_OUT = 6'b010000,
    ST_SKIP = 6'b100000
  } sfp_ser_e;
  typedef struct packed {
    logic lane_three;
    logic lane_two;
    logic lane_one;
    logic lane_zero;
  } sfp_lanes_s;
endpackage

// ---- tb/sfp_host_model.sv ----
`timescale 1ns/100ps
module sfp_host_model
  import sfp_pkg::*;
(
  input wire logic i_clk,
  input wire sfp_pkg::sfp_lanes_s i_out,
  input wire sfp_pkg::sfp_lanes_s i_oe,
  output logic o_sclk,
  output logic o_cs_n,
  output sfp_pkg::sfp_lanes_s o_pins
);
  logic mosi;
  logic wp_n;
  logic pause_n;
  logic last_one;
  // Select starts low so that an unarmed device can be probed
  initial begin
    o_cs_n = 1'b0;
    o_sclk = 1'b0;
    mosi = 1'b0;
    wp_n = 1'b1;
    pause_n = 1'b1;
    last_one = 1'b0;
  end
  // ==========
  // Wire resolution; a floated lane one shows the inverse of its last driven value, other lanes show the host's pins
  always_comb begin
    o_pins.lane_zero = i_oe.lane_zero ? i_out.lane_zero : mosi;
    o_pins.lane_one = i_oe.lane_one ? i_out.lane_one : ~last_one;
    o_pins.lane_two = i_oe.lane_two ? i_out.lane_two : wp_n;
    o_pins.lane_three = i_oe.lane_three ? i_out.lane_three : pause_n;
  end
  always @(posedge i_clk) begin
    if (i_oe.lane_one) last_one <= i_out.lane_one;
  end
  task sel(input logic v);
    @(posedge i_clk);
    o_cs_n <= v;
    repeat (8) @(posedge i_clk);
  endtask
  // Mode 0: clock idles low, bits go out before each rise
  task xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge i_clk);
      mosi <= tx[i];
      repeat (8) @(posedge i_clk);
      o_sclk <= 1'b1;
      rx[i] = o_pins.lane_one;
      repeat (7) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
  endtask
endmodule

// ---- tb/sfp_pins_properties.sv ----
`timescale 1ns/100ps
module sfp_pins_chk
  import sfp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire sfp_pkg::sfp_lanes_s o_lane_out,
  input wire sfp_pkg::sfp_lanes_s o_lane_oe,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr
);
  logic seen_high;
  logic armed;
  // ==========
  // Pin-level arming seen ahead of the design's synchroniser
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      seen_high <= 1'b0;
      armed <= 1'b0;
    end else begin
      if (i_cs_n) seen_high <= 1'b1;
      if (seen_high && !i_cs_n) armed <= 1'b1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_float_idle;
    i_cs_n [*8] |-> o_lane_oe == 4'h0;
  endproperty
  a_float_idle: assert property (p_float_idle) else $error("lanes driven while deselected");
  property p_float_deselect;
    $rose(i_cs_n) |-> ##[1:6] (o_lane_oe == 4'h0);
  endproperty
  a_float_deselect: assert property (p_float_deselect) else $error("lanes still driven after deselect");
  property p_unarmed;
    !armed |-> o_lane_oe == 4'h0;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("lanes driven before first select fall");
  property p_out_on_fall;
    $changed(o_lane_out.lane_one) && o_lane_oe.lane_one && $past(o_lane_oe.lane_one) |-> !$past(i_sclk, 2);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output bit changed away from clock fall");
  property p_ready_once;
    i_psel && !i_penable |=> o_pready ##1 !o_pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready not one cycle after setup");
  property p_ready_cause;
    o_pready |-> $past(i_psel) && !$past(i_penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
  property p_err_unmapped;
    i_psel && !i_penable && !(i_paddr inside {12'h000, 12'h004, 12'h008}) |=> o_pslverr && o_prdata == 32'h0;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
  property p_no_err_mapped;
    i_psel && !i_penable && (i_paddr inside {12'h000, 12'h004, 12'h008}) |=> !o_pslverr;
  endproperty
  a_no_err_mapped: assert property (p_no_err_mapped) else $error("mapped access refused");
endmodule
bind sfp_flash_pins sfp_pins_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sclk(i_sclk),
  .i_cs_n(i_cs_n), .o_lane_out(o_lane_out), .o_lane_oe(o_lane_oe), .i_psel(i_psel),
  .i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));

// ---- tb/tb_serial_flash_pin_interface.sv ----
`timescale 1ns/100ps
module tb_serial_flash_pin_interface;
  import sfp_pkg::*;
  typedef struct packed {
    logic [11:0] addr;
    logic we;
    logic [31:0] wdata;
    logic [31:0] rexp;
    logic eexp;
  } sfp_row_s;
  logic i_clk;
  logic i_sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sclk;
  logic cs_n;
  sfp_lanes_s pins;
  sfp_lanes_s lout;
  sfp_lanes_s loe;
  int fail_count = 0;
  int checks_done = 0;
  logic [31:0] r;
  logic e;
  logic [7:0] b;
  logic [63:0] uid = {32'h01234567, 32'h5a5a0f0f};
  sfp_row_s rows [9] = '{
    '{12'h000, 1'b0, 32'h0, 32'h00010000, 1'b0}, '{12'h004, 1'b0, 32'h0, 32'h89abcdef, 1'b0},
    '{12'h008, 1'b0, 32'h0, 32'h01234567, 1'b0}, '{12'h004, 1'b1, 32'h5a5a0f0f, 32'h0, 1'b0},
    '{12'h004, 1'b0, 32'h0, 32'h5a5a0f0f, 1'b0}, '{12'h000, 1'b1, 32'hffffffff, 32'h0, 1'b0},
    '{12'h000, 1'b0, 32'h0, 32'h00010000, 1'b0}, '{12'h00c, 1'b0, 32'h0, 32'h0, 1'b1},
    '{12'h00c, 1'b1, 32'h1, 32'h0, 1'b1}};
  always #5 i_clk = ~i_clk;
  sfp_flash_pins DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_lane_in(pins),
    .o_lane_out(lout), .o_lane_oe(loe), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
  sfp_host_model host (.i_clk(i_clk), .i_out(lout), .i_oe(loe), .o_sclk(sclk), .o_cs_n(cs_n), .o_pins(pins));
  task results;
    if (fail_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd, output logic er);
    int k;
    @(posedge i_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge i_clk);
    penable <= 1'b1;
    // Ready is read at the rising edge, before the slave's update lands
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      $display("unexpected at %0t: no bus answer", $time);
      fail_count++;
      results();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task frame(input logic [7:0] op, input int n, output logic [7:0] rx);
    host.sel(1'b0);
    host.xfer(op, 8, rx);
    repeat (n) host.xfer(8'h00, 8, rx);
    host.sel(1'b1);
  endtask
  // Status write, then wait for the busy bit to drop
  task wrsr(input logic [7:0] v);
    int k;
    frame(OP_WREN, 0, b);
    host.sel(1'b0);
    host.xfer(OP_WRSR, 8, b);
    host.xfer(v, 8, b);
    host.sel(1'b1);
    for (k = 0; k < 200; k++) begin
      apb(REG_STAT, 1'b0, 32'h0, r, e);
      if (r[0] === 1'b0) break;
    end
    if (k == 200) begin
      $display("unexpected at %0t: still busy", $time);
      fail_count++;
      results();
    end
  endtask
  initial begin
    repeat (100000) @(posedge i_clk);
    $display("unexpected at %0t: run limit", $time);
    fail_count++;
    results();
  end
  initial begin
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    // ==========
    // Select low since reset: opcode must be ignored
    host.xfer(OP_WREN, 8, b);
    host.sel(1'b1);
    apb(REG_STAT, 1'b0, 32'h0, r, e);
    chk(r, 32'h0);
    host.sel(1'b0);
    host.sel(1'b1);
    // ==========
    // Register table
    foreach (rows[i]) begin
      apb(rows[i].addr, rows[i].we, rows[i].wdata, r, e);
      chk({31'h0, e}, {31'h0, rows[i].eexp});
      if (!rows[i].we) chk(r, rows[i].rexp);
    end
    // ==========
    // Link traffic
    frame(OP_WREN, 0, b);
    frame(OP_RDSR1, 2, b);
    chk({24'h0, b}, 32'h02);
    host.sel(1'b0);
    host.xfer(OP_WRDI, 7, b);
    host.sel(1'b1);
    frame(OP_RDSR1, 1, b);
    chk({24'h0, b}, 32'h02);
    host.sel(1'b0);
    host.xfer(OP_UID, 8, b);
    repeat (4) host.xfer(8'h00, 8, b);
    for (int k = 0; k < 8; k++) begin
      host.xfer(8'h00, 8, b);
      chk({24'h0, b}, {24'h0, uid[63 - 8 * k -: 8]});
    end
    host.sel(1'b1);
    // Pause mid-opcode; clocks during the pause must be ignored
    host.sel(1'b0);
    host.xfer(OP_RDSR1, 4, b);
    host.pause_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    apb(REG_STAT, 1'b0, 32'h0, r, e);
    chk({31'h0, r[17]}, 32'h1);
    host.xfer(8'hff, 4, b);
    chk({28'h0, loe}, 32'h0);
    host.pause_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    host.xfer(8'h50, 4, b);
    host.xfer(8'h00, 8, b);
    chk({24'h0, b}, 32'h02);
    host.sel(1'b1);
    // Quad read without four_lane_enable
    host.sel(1'b0);
    host.xfer(OP_QOUT, 8, b);
    repeat (5) host.xfer(8'h00, 8, b);
    chk({28'h0, loe}, 32'h0);
    host.sel(1'b1);
    // Locked status with write protect asserted
    wrsr(8'h80);
    host.wp_n <= 1'b0;
    wrsr(8'h84);
    chk({24'h0, r[7:0]}, 32'h80);
    results();
  end
endmodule
